// File: src/pcs_status.sv
// Purpose: Configuration status outputs toward user logic
// Assumes: All inputs synchronous to clk; Device Control and Command
//   register images come from the configuration space
// Notes: Every output is a flip-flop, forced low in reset; link-down and
//   link state follow the training state two edges late
`timescale 1ns/10ps
`include "pcs_defines.svh"

module pcs_status #(
  parameter int NUM_PF = 4,
  parameter int NUM_VF = 252
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link side inputs
  input wire pcs_pkg::pcs_ltssm_t ltssm,
  input wire logic rx_detected,
  input wire logic dl_active,
  input wire logic [4:0] lane_count,
  input wire logic [1:0] rate_code,
  // Configuration space images
  input wire logic [15:0] dev_ctrl,
  input wire logic [16*NUM_PF-1:0] pf_command,
  input wire logic [NUM_VF-1:0] vf_enable,
  input wire logic [16*NUM_VF-1:0] vf_command,
  // Status outputs
  output logic link_down,
  output logic [1:0] link_status,
  output logic [2:0] negotiated_width,
  output logic [1:0] current_speed,
  output logic [1:0] max_payload,
  output logic [2:0] max_read_req,
  output logic [4*NUM_PF-1:0] function_status,
  output logic [2*NUM_VF-1:0] virtual_function_flags
);

  // LinkUp from the training history
  logic link_up;
  // Link state registers
  logic down_ff;
  logic nxt_down;
  logic [1:0] stat_ff;
  logic [1:0] nxt_stat;
  logic [2:0] width_ff;
  logic [2:0] nxt_width;
  // Rate and limit registers
  logic [1:0] speed_ff;
  logic [1:0] nxt_speed;
  logic [1:0] mps_ff;
  logic [1:0] nxt_mps;
  logic [2:0] mrrs_ff;
  logic [2:0] nxt_mrrs;
  // Function enable registers
  logic [4*NUM_PF-1:0] fn_ff;
  logic [4*NUM_PF-1:0] nxt_fn;
  logic [2*NUM_VF-1:0] vf_ff;
  logic [2*NUM_VF-1:0] nxt_vf;

  // Lane count to width code
  function automatic logic [2:0] width_code(input logic [4:0] lanes);
    case (lanes)
      5'h01: width_code = `PCS_W_X1;
      5'h02: width_code = `PCS_W_X2;
      5'h04: width_code = `PCS_W_X4;
      5'h08: width_code = `PCS_W_X8;
      5'h10: width_code = `PCS_W_X16;
      default: width_code = `PCS_W_X1;
    endcase
  endfunction

  // Rate code with the reserved value folded onto the top rate
  function automatic logic [1:0] speed_code(input logic [1:0] rate);
    if (rate == `PCS_RATE_RSVD) begin
      speed_code = `PCS_RATE_8G0;
    end else begin
      speed_code = rate;
    end
  endfunction

  // Read limit code, reserved codes fall back to the largest size
  function automatic logic [2:0] read_limit(input logic [2:0] code);
    if (code > `PCS_DC_MRRS_MAX) begin
      read_limit = `PCS_DC_MRRS_MAX;
    end else begin
      read_limit = code;
    end
  endfunction

  // Four enables of one function from its Command image
  function automatic logic [3:0] cmd_bits(input logic [15:0] cmd);
    cmd_bits = {cmd[`PCS_CMD_INTX], cmd[`PCS_CMD_BME], cmd[`PCS_CMD_MEM],
      cmd[`PCS_CMD_IO]};
  endfunction

  // **********************************************
  // LinkUp derivation
  // **********************************************

  // LinkUp from the training state history
  pcs_linkup u_linkup (
    .clk(clk),
    .rst(rst),
    .ltssm(ltssm),
    .link_up(link_up)
  );

  // **********************************************
  // Link state outputs
  // **********************************************

  // Link-down, link state code and negotiated width
  always_comb begin
    nxt_down = !link_up;
    // Link state code in ascending order of progress
    if (!rx_detected) begin
      nxt_stat = `PCS_LS_NO_RX;
    end else if (!link_up) begin
      nxt_stat = `PCS_LS_TRAIN;
    end else if (!dl_active) begin
      nxt_stat = `PCS_LS_DL_INIT;
    end else begin
      nxt_stat = `PCS_LS_DL_UP;
    end
    // Width is refreshed only once the link is fully up
    if (nxt_stat == `PCS_LS_DL_UP) begin
      nxt_width = width_code(lane_count);
    end else begin
      nxt_width = width_ff; // Last valid width is kept
    end
  end

  // Link state registers, link-down held low in reset
  always_ff @(posedge clk) begin
    if (rst) begin
      down_ff <= 1'b0;
      stat_ff <= `PCS_LS_NO_RX;
      width_ff <= `PCS_W_X1;
    end else begin
      down_ff <= nxt_down;
      stat_ff <= nxt_stat;
      width_ff <= nxt_width;
    end
  end

  // Link state outputs straight from their registers
  assign link_down = down_ff;
  assign link_status = stat_ff;
  assign negotiated_width = width_ff;

  // **********************************************
  // Rate and size limits
  // **********************************************

  // Rate code and the two Device Control limits
  always_comb begin
    nxt_speed = speed_code(rate_code);
    nxt_mps = dev_ctrl[`PCS_DC_MPS_LO +: 2];
    nxt_mrrs = read_limit(dev_ctrl[`PCS_DC_MRRS_LO +: 3]);
  end

  // Rate and limit registers
  always_ff @(posedge clk) begin
    if (rst) begin
      speed_ff <= `PCS_RATE_2G5;
      mps_ff <= 2'h0;
      mrrs_ff <= 3'h0;
    end else begin
      speed_ff <= nxt_speed;
      mps_ff <= nxt_mps;
      mrrs_ff <= nxt_mrrs;
    end
  end

  // Rate and limit outputs
  assign current_speed = speed_ff;
  assign max_payload = mps_ff;
  assign max_read_req = mrrs_ff;

  // **********************************************
  // Function enables
  // **********************************************

  // Command enables per function and flags per virtual function
  always_comb begin
    nxt_fn = '0;
    nxt_vf = '0;
    for (int n = 0; n < NUM_PF; n++) begin
      nxt_fn[4*n +: 4] = cmd_bits(pf_command[16*n +: 16]);
    end
    for (int k = 0; k < NUM_VF; k++) begin
      nxt_vf[2*k] = vf_enable[k];
      nxt_vf[2*k+1] = vf_command[16*k+`PCS_CMD_BME];
    end
  end

  // Enable registers
  always_ff @(posedge clk) begin
    if (rst) begin
      fn_ff <= '0;
      vf_ff <= '0;
    end else begin
      fn_ff <= nxt_fn;
      vf_ff <= nxt_vf;
    end
  end

  // Enable outputs
  assign function_status = fn_ff;
  assign virtual_function_flags = vf_ff;

endmodule

// File: src/pcs_defines.svh
// Purpose: Constants for the configuration status output block
// Assumes: Included by bare name from design files
// Notes: Codes follow the link status and rate encodings
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// Link state codes
`define PCS_LS_NO_RX 2'h0
`define PCS_LS_TRAIN 2'h1
`define PCS_LS_DL_INIT 2'h2
`define PCS_LS_DL_UP 2'h3

// Link rate codes
`define PCS_RATE_2G5 2'h0
`define PCS_RATE_5G0 2'h1
`define PCS_RATE_8G0 2'h2
`define PCS_RATE_RSVD 2'h3

// Negotiated width codes
`define PCS_W_X1 3'h0
`define PCS_W_X2 3'h1
`define PCS_W_X4 3'h2
`define PCS_W_X8 3'h3
`define PCS_W_X16 3'h4

// Device Control field positions
`define PCS_DC_MPS_LO 5
`define PCS_DC_MRRS_LO 12
`define PCS_DC_MRRS_MAX 3'h5

// Command register bit positions
`define PCS_CMD_IO 0
`define PCS_CMD_MEM 1
`define PCS_CMD_BME 2
`define PCS_CMD_INTX 10

`endif

// File: src/pcs_pkg.sv
// Purpose: Types for the configuration status output block
// Assumes: Nothing
// Notes: One-hot training states
package pcs_pkg;
  typedef enum logic [8:0] {
    PCS_DETECT = 9'h001,
    PCS_POLLING = 9'h002,
    PCS_CONFIG = 9'h004,
    PCS_RECOVERY = 9'h008,
    PCS_L0 = 9'h010,
    PCS_L0S = 9'h020,
    PCS_L1 = 9'h040,
    PCS_L2 = 9'h080,
    PCS_OTHER = 9'h100
  } pcs_ltssm_t;
endpackage

// File: src/pcs_linkup.sv
// Purpose: Derive the LinkUp state variable from the training state
// Assumes: Training state is a one-hot code synchronous to clk
// Notes: Remembers whether Configuration came via Detect then Polling
`timescale 1ns/10ps
`include "pcs_defines.svh"

module pcs_linkup (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Training state
  input wire pcs_pkg::pcs_ltssm_t ltssm,
  // Derived LinkUp
  output logic link_up
);

  pcs_pkg::pcs_ltssm_t prev_ff;
  pcs_pkg::pcs_ltssm_t nxt_prev;
  logic cold_ff;
  logic nxt_cold;
  logic up_ff;
  logic nxt_up;

  // **********************************************
  // Path tracking and LinkUp decision
  // **********************************************

  // Next values for history and LinkUp
  always_comb begin
    nxt_prev = ltssm;
    nxt_cold = cold_ff;
    nxt_up = 1'b0;
    case (ltssm)
      pcs_pkg::PCS_DETECT: begin
        nxt_cold = 1'b0;
      end
      pcs_pkg::PCS_POLLING: begin
        nxt_cold = (prev_ff == pcs_pkg::PCS_DETECT) ||
                   (prev_ff == pcs_pkg::PCS_POLLING && cold_ff);
      end
      pcs_pkg::PCS_CONFIG: begin
        // Entry from Polling on a cold path keeps LinkUp low
        if (prev_ff != pcs_pkg::PCS_CONFIG) begin
          nxt_cold = (prev_ff == pcs_pkg::PCS_POLLING) && cold_ff;
        end
        nxt_up = !nxt_cold;
      end
      pcs_pkg::PCS_RECOVERY, pcs_pkg::PCS_L0, pcs_pkg::PCS_L0S,
      pcs_pkg::PCS_L1, pcs_pkg::PCS_L2: begin
        nxt_cold = 1'b0;
        nxt_up = 1'b1;
      end
      default: begin
        nxt_cold = 1'b0;
        nxt_up = 1'b0;
      end
    endcase
  end

  // History registers
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_ff <= pcs_pkg::PCS_DETECT;
      cold_ff <= 1'b0;
      up_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
      cold_ff <= nxt_cold;
      up_ff <= nxt_up;
    end
  end

  assign link_up = up_ff;

endmodule

// File: tb/pcs_status_checker.sv
// Purpose: Assertions on the status outputs
// Assumes: Bound into pcs_status
// Notes: Outputs trail inputs by one edge, link-down by two
`timescale 1ns/10ps
module pcs_status_checker #(
  parameter int NUM_PF = 4
) (
  // Clock, reset and sources
  input wire logic clk,
  input wire logic rst,
  input wire pcs_pkg::pcs_ltssm_t ltssm,
  input wire logic [1:0] rate_code,
  input wire logic [15:0] dev_ctrl,
  input wire logic [16*NUM_PF-1:0] pf_command,
  // Watched outputs
  input wire logic link_down,
  input wire logic [2:0] negotiated_width,
  input wire logic [1:0] current_speed,
  input wire logic [1:0] max_payload,
  input wire logic [2:0] max_read_req,
  input wire logic [4*NUM_PF-1:0] function_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Cold and warm paths into Configuration
  sequence s_cold;
    ltssm == pcs_pkg::PCS_DETECT ##1 ltssm == pcs_pkg::PCS_POLLING
      ##1 ltssm == pcs_pkg::PCS_CONFIG;
  endsequence
  sequence s_warm;
    ltssm == pcs_pkg::PCS_RECOVERY ##1 ltssm == pcs_pkg::PCS_CONFIG;
  endsequence
  // Properties
  property p_rst_low;
    disable iff (1'b0) rst |=> !link_down;
  endproperty
  property p_up;
    |ltssm[7:3] |-> ##2 !link_down;
  endproperty
  property p_cold;
    s_cold |-> ##2 link_down;
  endproperty
  property p_warm;
    s_warm |-> ##2 !link_down;
  endproperty
  property p_no_rsvd;
    current_speed != 2'h3;
  endproperty
  property p_width;
    negotiated_width <= 3'h4;
  endproperty
  property p_speed;
    rate_code != 2'h3 |=> current_speed == $past(rate_code);
  endproperty
  property p_mps;
    1'b1 |=> max_payload == $past(dev_ctrl[6:5]);
  endproperty
  property p_mrrs;
    dev_ctrl[14:13] == 2'h3 |=> max_read_req == 3'h5;
  endproperty
  property p_fs;
    1'b1 |=> function_status[7:4] ==
      {$past(pf_command[26]), $past(pf_command[18:16])};
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("down in reset");
  a_up: assert property (p_up) else $error("down while up");
  a_cold: assert property (p_cold) else $error("cold config up");
  a_warm: assert property (p_warm) else $error("warm config down");
  a_no_rsvd: assert property (p_no_rsvd) else $error("speed 3");
  a_speed: assert property (p_speed) else $error("speed code");
  a_width: assert property (p_width) else $error("width code");
  a_mps: assert property (p_mps) else $error("payload code");
  a_mrrs: assert property (p_mrrs) else $error("read clamp");
  a_fs: assert property (p_fs) else $error("function 1 bits");
endmodule
bind pcs_status pcs_status_checker #(.NUM_PF(NUM_PF)) chk_i (.*);

// File: tb/pcs_user_model.sv
// Purpose: User logic consuming the status outputs
// Assumes: Four physical functions
// Notes: Width is taken only while the link is fully up
`timescale 1ns/10ps
module pcs_user_model (
  // Clock
  input wire logic clk,
  // Status from the block
  input wire logic [1:0] link_status,
  input wire logic [2:0] negotiated_width,
  input wire logic [1:0] max_payload,
  input wire logic [2:0] max_read_req,
  input wire logic [15:0] function_status,
  // Limits kept by user traffic
  output int pay_bytes,
  output int rd_bytes,
  output int lanes,
  output logic [3:0] bm_ok
);
  // Size limits and request gates
  assign pay_bytes = 128 << max_payload;
  assign rd_bytes = 128 << max_read_req;
  assign bm_ok = {function_status[14], function_status[10],
    function_status[6], function_status[2]};
  // Lane count latched while state code is 3
  always_ff @(posedge clk) begin
    if (link_status == 2'h3) begin
      lanes <= 1 << negotiated_width;
    end
  end
endmodule

// File: tb/tb_pcs_status.sv
// Purpose: Self-checking bench for pcs_status
// Assumes: Seed fixed at 89
// Notes: Outputs sampled 1 ns after an edge
`timescale 1ns/10ps
module tb_pcs_status;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pcs_pkg::pcs_ltssm_t ltssm = pcs_pkg::PCS_DETECT;
  logic rx_detected = 1'b0;
  logic dl_active = 1'b0;
  logic [4:0] lane_count = 5'h01;
  logic [1:0] rate_code = 2'h0;
  logic [15:0] dev_ctrl = 16'h0000;
  logic [63:0] pf_command = '0;
  logic [251:0] vf_enable = '0;
  logic [4031:0] vf_command = '0;
  logic link_down;
  logic [1:0] link_status, current_speed, max_payload;
  logic [2:0] negotiated_width, max_read_req, rq;
  logic [15:0] function_status;
  logic [3:0] bm_ok, bm_e;
  logic [503:0] vf_flags;
  int pay_bytes, rd_bytes, lanes, errors, checks_done, seed, i;
  int st_k [10] = '{0, 1, 2, 4, 5, 6, 7, 3, 2, 8};
  logic [9:0] st_dn = 10'h207;
  // Design and user-side model
  pcs_status pcs_status_i (.clk(clk), .rst(rst), .ltssm(ltssm),
    .rx_detected(rx_detected), .dl_active(dl_active),
    .lane_count(lane_count), .rate_code(rate_code),
    .dev_ctrl(dev_ctrl), .pf_command(pf_command),
    .vf_enable(vf_enable), .vf_command(vf_command),
    .link_down(link_down), .link_status(link_status),
    .negotiated_width(negotiated_width), .current_speed(current_speed),
    .max_payload(max_payload), .max_read_req(max_read_req),
    .function_status(function_status), .virtual_function_flags(vf_flags));
  pcs_user_model pcs_user_model_i (.clk(clk), .link_status(link_status),
    .negotiated_width(negotiated_width), .max_payload(max_payload),
    .max_read_req(max_read_req), .function_status(function_status),
    .pay_bytes(pay_bytes), .rd_bytes(rd_bytes), .lanes(lanes),
    .bm_ok(bm_ok));
  // Comparison and closing
  task automatic chk(string n, logic [511:0] e, logic [511:0] s);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %0h got %0h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Expected packings
  function automatic logic [15:0] exp_fs(logic [63:0] c);
    for (int n = 0; n < 4; n++) begin
      exp_fs[4*n+:4] = {c[16*n+10], c[16*n+:3]};
    end
  endfunction
  function automatic logic [503:0] exp_vf(logic [251:0] e, logic [4031:0] c);
    for (int k = 0; k < 252; k++) begin
      exp_vf[2*k+:2] = {c[16*k+2], e[k]};
    end
  endfunction
  // Clock
  initial begin
    forever #25 clk = ~clk;
  end
  // Watchdog, about five times the expected run
  initial begin
    #(50 * 1000);
    errors++;
    finish_test;
  end
  // Main sequence
  initial begin
    seed = 89;
    repeat (5) @(posedge clk);
    #1 chk("down in reset", 0, link_down);
    @(posedge clk) rst <= 1'b0;
    for (i = 0; i < 10; i++) begin
      @(posedge clk) ltssm <= pcs_pkg::pcs_ltssm_t'(9'h001 << st_k[i]);
      repeat (3) @(posedge clk);
      #1 chk("link_down", st_dn[i], link_down);
    end
    // Cold path with one cycle each in Detect and Polling
    @(posedge clk) ltssm <= pcs_pkg::PCS_DETECT;
    @(posedge clk) ltssm <= pcs_pkg::PCS_POLLING;
    @(posedge clk) ltssm <= pcs_pkg::PCS_CONFIG;
    repeat (3) @(posedge clk);
    #1 chk("cold config", 1, link_down);
    chk("status idle", 0, link_status);
    $display("training walk done");
    @(posedge clk) ltssm <= pcs_pkg::PCS_L0;
    rx_detected <= 1'b1;
    dl_active <= 1'b1;
    for (i = 0; i < 5; i++) begin
      @(posedge clk) lane_count <= 5'(1 << i);
      repeat (3) @(posedge clk);
      #1 chk("status up", 3, link_status);
      chk("width", i, negotiated_width);
      chk("lanes", 1 << i, lanes);
    end
    // Init and training codes, width held while not fully up
    @(posedge clk) dl_active <= 1'b0;
    lane_count <= 5'h02;
    repeat (3) @(posedge clk);
    #1 chk("status init", 2, link_status);
    chk("width held", 4, negotiated_width);
    @(posedge clk) ltssm <= pcs_pkg::PCS_POLLING;
    repeat (3) @(posedge clk);
    #1 chk("status train", 1, link_status);
    $display("width table done");
    for (i = 0; i < 40; i++) begin
      @(posedge clk) dev_ctrl <= (i < 8) ? 16'(i << 12) : 16'($random(seed));
      rate_code <= 2'(i);
      pf_command <= {$random(seed), $random(seed)};
      vf_enable <= 252'({8{$random(seed)}});
      vf_command <= 4032'({126{$random(seed)}});
      repeat (2) @(posedge clk);
      #1 rq = dev_ctrl[14:12];
      chk("payload", dev_ctrl[6:5], max_payload);
      chk("read req", rq > 5 ? 5 : rq, max_read_req);
      chk("speed", rate_code == 3 ? 2 : rate_code, current_speed);
      chk("pf", exp_fs(pf_command), function_status);
      chk("vf", exp_vf(vf_enable, vf_command), vf_flags);
      chk("pay bytes", 128 << dev_ctrl[6:5], pay_bytes);
      chk("rd bytes", 128 << (rq > 5 ? 5 : rq), rd_bytes);
      bm_e = {pf_command[50], pf_command[34], pf_command[18], pf_command[2]};
      chk("bm ok", bm_e, bm_ok);
    end
    $display("random images done");
    finish_test;
  end
endmodule
